// [hdl/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
  // register indices on the peripheral bus
  localparam logic [2:0] IDX_CONV_MODE    = 3'h0;
  localparam logic [2:0] IDX_CHAN_SEL     = 3'h1;
  localparam logic [2:0] IDX_CONV_RESULT  = 3'h2;
  localparam logic [2:0] IDX_PF_MODE      = 3'h3;
  localparam logic [2:0] IDX_PF_THRESHOLD = 3'h4;
  // field positions
  localparam int RUN_BIT   = 7;    // conversion enable in mode register
  localparam int FR_LSB    = 3;    // conversion-time select, low bit
  localparam int FR_MSB    = 5;    // conversion-time select, high bit
  localparam int CHAN_W    = 3;    // stored channel bits, rest reads zero
  // reset values
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] PF_RST     = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  // wait cycles inserted on a stretched access
  localparam logic [1:0] WAIT_CYC   = 2'h1;
endpackage : adc_ctrl_pkg

// [hdl/adc_ctrl.sv]
`timescale 1ns/1ps
// Overview of operation
// R01: software writes zero to channel bits 7..3
// R02: channel register write gets one wait cycle
// R03: no channel write on stopped main oscillator
// R04: mode/channel write may spoil held result
// R05: software reads result before rewriting mode/channel
// R06: result register read gets one wait cycle
// R07: no result read on stopped main oscillator
// R08: power-fail mode write gets one wait cycle
// R09: power-fail threshold write gets one wait cycle
// R10: no pf mode write on stopped oscillator
// R11: no pf threshold write on stopped oscillator
// R12: 14 us from setup to start
// R13: first two setup steps in either order
// R14: skipped setup means discard first result
// R15: time select bits 5..3 set conversion length
// R16: stop conversion before changing time select
// R17: mode/channel write beats result store, no irq
// R18: wait means ready held low one clock
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int RES_W        = 10,  // converter result width
  parameter int BASE_CYC     = 16,  // conversion cycles for select code 0
  parameter int FIRST_EXTRA  = 32   // extra cycles of first conversion after start
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // peripheral bus from the cpu core
  input  wire logic [2:0]       busAddr,
  input  wire logic             busWr,
  input  wire logic             busRd,
  input  wire logic [15:0]      busWdata,
  output logic      [15:0]      busRdata,
  output logic                  busReady,
  // converter core
  input  wire logic [RES_W-1:0] coreData,
  output logic                  coreRun,
  output logic [CHAN_W-1:0]     chanSel,
  output logic [2:0]            convTimeSel,
  // power-fail comparator settings
  output logic [7:0]            pfMode,
  output logic [7:0]            pfThreshold,
  // conversion end event
  output logic                  conversion_end_irq
);

  // sequencer states: stopped, or converting back to back
  typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_state_e;

  // bus access tracking
  logic              accPend_r;    // access accepted, not yet completed
  logic [1:0]        waitLeft_r;   // wait cycles still to insert
  logic              busReady_r;   // completion pulse
  logic [15:0]       busRdata_r;   // read data captured at completion
  // registers
  logic [7:0]        modeReg_r;    // conv_mode_reg
  logic [CHAN_W-1:0] chanReg_r;    // channel_select_reg
  logic [RES_W-1:0]  resultReg_r;  // conv_result_reg
  logic [7:0]        pfMode_r;     // pwrfail_cmp_mode_reg
  logic [7:0]        pfThresh_r;   // pwrfail_threshold_reg
  // conversion sequencing
  conv_state_e       state_r;
  logic [31:0]       convCnt_r;    // cycles left in current conversion
  logic              irq_r;        // conversion end pulse
  // decode
  logic              isStretched;  // access needs a wait cycle
  logic              doAccess;     // access completes this cycle
  logic              ctlWrite;     // mode or channel write completes
  logic [31:0]       convLen;      // length from time select field

  // which accesses are stretched
  // only read when the access is accepted; the cpu holds address and
  // direction until ready, so the later cycles of the access agree
  always_comb begin
    isStretched = 1'b0;
    if (busWr) begin
      // channel, mode and power-fail writes are stretched
      isStretched = (busAddr == IDX_CHAN_SEL) ||     // [R02]
                    (busAddr == IDX_CONV_MODE) ||
                    (busAddr == IDX_PF_MODE) ||      // [R08]
                    (busAddr == IDX_PF_THRESHOLD);   // [R09]
    end else if (busRd) begin
      // result reads are stretched
      isStretched = (busAddr == IDX_CONV_RESULT);    // [R06]
    end
  end

  // an accepted access completes once its wait cycles have run out
  assign doAccess = accPend_r && (waitLeft_r == 2'h0);
  // mode or channel write landing now; it beats a result store and
  // restarts the count, so the held result may not match new settings
  assign ctlWrite = doAccess && busWr &&
                    ((busAddr == IDX_CONV_MODE) || (busAddr == IDX_CHAN_SEL));

  // per-conversion length from time select bits
  // each step of the code doubles the length; software stops the
  // converter before a change, so no running count is cut short
  assign convLen = 32'(BASE_CYC) << modeReg_r[FR_MSB:FR_LSB];  // [R15]

  // bus handshake: accept, hold ready low for waits, then pulse ready
  // a request still held in its ready cycle is not taken a second time
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      accPend_r  <= 1'b0;
      waitLeft_r <= 2'h0;
      busReady_r <= 1'b0;
    end else begin
      busReady_r <= 1'b0;
      if (doAccess) begin
        // complete the access
        accPend_r  <= 1'b0;
        busReady_r <= 1'b1;
      end else if (accPend_r) begin
        // ready stays low during the wait
        waitLeft_r <= waitLeft_r - 2'h1;  // [R18]
      end else if ((busWr || busRd) && !busReady_r) begin
        // new access
        accPend_r  <= 1'b1;
        waitLeft_r <= isStretched ? WAIT_CYC : 2'h0;  // [R18]
      end
    end
  end

  // read data mux, captured when the access completes
  // data stands until the next completed read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busRdata_r <= 16'h0000;
    end else if (doAccess && busRd) begin
      unique case (busAddr)
        IDX_CONV_MODE:    busRdata_r <= {8'h00, modeReg_r};
        IDX_CHAN_SEL:     busRdata_r <= {{(16-CHAN_W){1'b0}}, chanReg_r};
        IDX_CONV_RESULT:  busRdata_r <= {{(16-RES_W){1'b0}}, resultReg_r};
        IDX_PF_MODE:      busRdata_r <= {8'h00, pfMode_r};
        IDX_PF_THRESHOLD: busRdata_r <= {8'h00, pfThresh_r};
        default:          busRdata_r <= 16'h0000;  // unmapped reads zero
      endcase
    end
  end

  // register writes
  // only the low channel bits are kept; the rest always read as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      modeReg_r  <= MODE_RST;
      chanReg_r  <= '0;
      pfMode_r   <= PF_RST;
      pfThresh_r <= THRESH_RST;
    end else if (doAccess && busWr) begin
      unique case (busAddr)
        IDX_CONV_MODE:    modeReg_r  <= busWdata[7:0];
        IDX_CHAN_SEL:     chanReg_r  <= busWdata[CHAN_W-1:0];  // upper bits dropped [R01]
        IDX_PF_MODE:      pfMode_r   <= busWdata[7:0];
        IDX_PF_THRESHOLD: pfThresh_r <= busWdata[7:0];
        default:          ;  // result and unmapped writes ignored
      endcase
    end
  end

  // conversion sequencer, continuous while run bit set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      convCnt_r <= 32'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // waiting for the run bit
          if (modeReg_r[RUN_BIT]) begin
            // first conversion runs longer than the set time
            state_r   <= ST_CONV;
            convCnt_r <= convLen + 32'(FIRST_EXTRA);  // [R15]
          end
        end
        ST_CONV: begin
          // count down the current conversion
          if (!modeReg_r[RUN_BIT]) begin
            state_r <= ST_IDLE;  // stopped by software
          end else if (ctlWrite) begin
            // rewrite restarts the count, at the length of the time select held before the write
            convCnt_r <= convLen;  // [R04]
          end else if (convCnt_r <= 32'h1) begin
            // last cycle: the store process below takes the result
            convCnt_r <= convLen;  // next conversion at set time [R15]
          end else begin
            convCnt_r <= convCnt_r - 32'h1;
          end
        end
      endcase
    end
  end

  // result store and end pulse; control write wins the collision
  // a blocked store drops the end pulse too, so no event is seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resultReg_r <= '0;
      irq_r       <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      if (state_r == ST_CONV && modeReg_r[RUN_BIT] && convCnt_r <= 32'h1 &&
          !ctlWrite) begin  // [R17]
        resultReg_r <= coreData;
        irq_r       <= 1'b1;
      end
    end
  end

  // outputs straight from flops
  // run and time select are fields of the mode register flops
  assign busRdata           = busRdata_r;
  assign busReady           = busReady_r;
  assign coreRun            = modeReg_r[RUN_BIT];
  assign chanSel            = chanReg_r;
  assign convTimeSel        = modeReg_r[FR_MSB:FR_LSB];
  assign pfMode             = pfMode_r;
  assign pfThreshold        = pfThresh_r;
  assign conversion_end_irq = irq_r;

endmodule : adc_ctrl

// [bench/adc_ctrl_asserts.sv]
`timescale 1ns/1ps
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  // watched ports
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [2:0]  busAddr,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [15:0] busWdata,
  input wire logic        busReady,
  input wire logic [2:0]  convTimeSel,
  input wire logic        conversion_end_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chan_wait_a: assert property ($rose(busWr) && busAddr == IDX_CHAN_SEL
    |-> !busReady [*3] ##1 busReady) else $error("chan write wait");
  res_wait_a: assert property ($rose(busRd) && busAddr == IDX_CONV_RESULT
    |-> !busReady [*3] ##1 busReady) else $error("result read wait");
  pfm_wait_a: assert property ($rose(busWr) && busAddr == IDX_PF_MODE
    |-> !busReady [*3] ##1 busReady) else $error("pf mode wait");
  pft_wait_a: assert property ($rose(busWr) && busAddr == IDX_PF_THRESHOLD
    |-> !busReady [*3] ##1 busReady) else $error("pf threshold wait");
  mode_rd_fast_a: assert property ($rose(busRd) && busAddr == IDX_CONV_MODE
    |-> !busReady [*2] ##1 busReady) else $error("mode read no wait");
  ready_pulse_a: assert property (busReady |=> !busReady)
    else $error("ready too long");
  time_sel_a: assert property (busReady && busWr && busAddr == IDX_CONV_MODE
    |-> convTimeSel == busWdata[FR_MSB:FR_LSB]) else $error("time select");
  write_wins_a: assert property (busReady && busWr && busAddr <= IDX_CHAN_SEL
    |-> !conversion_end_irq) else $error("end event after write");
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk chk (.sys_clk, .rst_n, .busAddr, .busWr, .busRd, .busWdata,
  .busReady, .convTimeSel, .conversion_end_irq);

// [bench/cpu_bus_model.sv]
`timescale 1ns/1ps
module cpu_bus_model (
  // bus
  input  wire logic        sys_clk,
  input  wire logic        busReady,
  input  wire logic [15:0] busRdata,
  output logic      [2:0]  busAddr,
  output logic             busWr,
  output logic             busRd,
  output logic      [15:0] busWdata
);
  // idle bus; always on main clock, never on a stopped oscillator
  initial begin
    busAddr = 3'h0;
    busWr = 1'b0;
    busRd = 1'b0;
    busWdata = 16'h0000;
  end
  // one access held until ready; lat counts edges
  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d,
                     output int lat, output logic [15:0] q);
    lat = 0;
    @(negedge sys_clk);
    busAddr = a;
    busWdata = d;
    busWr = w;
    busRd = !w;
    do begin
      @(posedge sys_clk);
      lat++;
    end while (!busReady && lat < 50);
    q = busRdata;
    @(negedge sys_clk);
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = ~a;
    busWdata = ~d;
  endtask : acc
endmodule : cpu_bus_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import adc_ctrl_pkg::*;
  localparam int BASE = 4;  // short conversion base
  localparam int FE   = 8;  // short extra length of the first conversion
  logic        sys_clk, rst_n, busWr, busRd, busReady, coreRun, conversion_end_irq;
  logic [2:0]  busAddr, chanSel, convTimeSel;
  logic [15:0] busWdata, busRdata, q;
  logic [7:0]  pfMode, pfThreshold;
  logic [9:0]  coreData;
  int          n_errors, num_checks, lat, c;
  adc_ctrl #(.BASE_CYC(BASE), .FIRST_EXTRA(FE)) DUT (.sys_clk, .rst_n, .busAddr, .busWr,
    .busRd, .busWdata, .busRdata, .busReady, .coreData, .coreRun, .chanSel,
    .convTimeSel, .pfMode, .pfThreshold, .conversion_end_irq);
  cpu_bus_model cpu (.sys_clk, .busReady, .busRdata, .busAddr, .busWr, .busRd, .busWdata);
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // count edges to next end event
  task automatic end_wait;
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (!conversion_end_irq && c < 2000);
  endtask : end_wait
  // write then read each register; wait cycle only where stretched
  task automatic t_wait;
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      d = (i == 1) ? 16'h0005 : 16'h006d;
      cpu.acc(1'b1, 3'(i), d, lat, q);
      chk(16'(lat), (i == 2) ? 16'h0003 : 16'h0004);
      cpu.acc(1'b0, 3'(i), 16'h0000, lat, q);
      chk(16'(lat), (i == 2) ? 16'h0004 : 16'h0003);
      chk(q, (i == 2) ? 16'h0000 : d);
    end
    chk({13'h0000, chanSel}, 16'h0005);
    chk({13'h0000, convTimeSel}, 16'h0005);
    chk({8'h00, pfMode}, 16'h006d);
    chk({8'h00, pfThreshold}, 16'h006d);
  endtask : t_wait
  // each time select: run, time the first end and the second
  task automatic t_conv;
    int c1;
    for (int s = 0; s < 8; s++) begin
      coreData = 10'h2a5 ^ 10'(s);
      // no reference setup step before run, so no spacing to
      cpu.acc(1'b1, IDX_CONV_MODE, 16'h0080 | 16'(s << FR_LSB), lat, q);
      chk(16'(lat), 16'h0004);
      end_wait();
      c1 = c;
      end_wait();
      chk(16'(c), 16'(BASE << s));
      // first run is longer; its end pulse shows one edge after the store
      chk(16'(c1), 16'((BASE << s) + FE + 1));
      cpu.acc(1'b0, IDX_CONV_RESULT, 16'h0000, lat, q);
      chk(16'(lat), 16'h0004);
      chk(q, 16'h02a5 ^ 16'(s));
      cpu.acc(1'b1, IDX_CONV_MODE, 16'(s << FR_LSB), lat, q);
      chk(16'(lat), 16'h0004);
    end
  endtask : t_conv
  // channel write landing on a store edge; timing holds for BASE of 4
  task automatic t_clash;
    cpu.acc(1'b1, IDX_CONV_MODE, 16'h0080, lat, q);
    chk(16'(lat), 16'h0004);
    chk({15'h0000, coreRun}, 16'h0001);
    end_wait();
    cpu.acc(1'b1, IDX_CHAN_SEL, 16'h0003, lat, q); // lands on the next store
    chk(16'(lat), 16'h0004);
    chk({13'h0000, chanSel}, 16'h0003);
    end_wait();
    chk(16'(c), 16'(BASE)); // count restarted by the write
    cpu.acc(1'b1, IDX_CONV_MODE, 16'h0000, lat, q);
    chk({15'h0000, coreRun}, 16'h0000);
  endtask : t_clash
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    coreData = 10'h2a5;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    t_wait();
    t_conv();
    t_clash();
    conclude();
  end
  // watchdog
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
endmodule : tb
